/* ccs_copy_mgr.sv */
`include "ccs_map.svh"
`default_nettype none
module ccs_copy_mgr
  import ccs_pkg::*;
#(
  parameter int SNS_DEPTH = 64,
  parameter int FIFO_D    = 8
) (
  // clock, reset, enable
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        ce_i,
  // command and configuration
  input  wire logic        start_i,
  input  wire logic [7:0]  func_i,
  input  wire logic [23:0] list_len_i,
  input  wire logic [2:0]  own_addr_i,
  input  wire logic        third_party_en_i,
  input  wire logic        remote_en_i,
  input  wire logic [15:0] max_blklen_i,
  input  wire logic        parity_err_i,
  input  wire logic        mgmt_fail_i,
  input  wire logic [3:0]  mgmt_key_i,
  // parameter list byte stream
  input  wire logic        par_valid_i,
  input  wire logic [7:0]  par_data_i,
  output logic             par_ready_o,
  // segment request to the data mover
  output logic             seg_valid_o,
  input  wire logic        seg_ready_i,
  output logic [7:0]       seg_num_o,
  output logic [2:0]       seg_src_addr_o,
  output logic [2:0]       seg_src_lun_o,
  output logic [2:0]       seg_dst_addr_o,
  output logic [2:0]       seg_dst_lun_o,
  output logic [15:0]      seg_blklen_o,
  output logic [31:0]      seg_count_o,
  output logic [31:0]      seg_src_lba_o,
  output logic [31:0]      seg_dst_lba_o,
  // transfer progress and failures
  input  wire logic        blk_done_i,
  input  wire logic        seq_len_bad_i,
  input  wire logic        self_fail_i,
  input  wire logic [3:0]  self_key_i,
  // managed target reports
  input  wire logic        tgt_chk_i,
  input  wire logic        tgt_is_dst_i,
  input  wire logic [7:0]  tgt_status_i,
  output logic             req_sense_o,
  input  wire logic        tgt_sns_valid_i,
  input  wire logic [7:0]  tgt_sns_data_i,
  input  wire logic        tgt_sns_last_i,
  output logic             tgt_sns_ready_o,
  // completion and sense readout
  output logic             busy_o,
  output logic             done_o,
  output logic             chk_cond_o,
  output logic [7:0]       sns_len_o,
  input  wire logic [7:0]  sns_addr_i,
  output logic [7:0]       sns_data_o
);
  if (SNS_DEPTH < 16 || SNS_DEPTH > 256) begin : g_bad
    $error("sense depth must be 16 to 256");
  end

  // ----------------------------------------
  // reset release
  // ----------------------------------------
  logic [1:0] rst_sq;                       // release synchroniser
  logic       rst_n;                        // internal reset
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_sq <= 2'b00;
    end else begin
      rst_sq <= {rst_sq[0], 1'b1};
    end
  end
  assign rst_n = rst_sq[1];

  // ----------------------------------------
  // parameter fifo
  // ----------------------------------------
  logic       f_vld;                        // byte waiting
  logic [7:0] f_dat;                        // head byte
  logic       pop;                          // parser takes byte
  // stalls on a busy mover so the list source feels back-pressure
  ccs_fifo #(.W(8), .D(FIFO_D)) u_fifo (
    .clk_i       (clk_i),
    .rst_n_i     (rst_n),
    .ce_i        (ce_i),
    .in_valid_i  (par_valid_i),
    .in_data_i   (par_data_i),
    .in_ready_o  (par_ready_o),
    .out_valid_o (f_vld),
    .out_data_o  (f_dat),
    .out_ready_i (pop)
  );

  // ----------------------------------------
  // descriptor fields
  // ----------------------------------------
  ccs_ctl_s    q, d;                        // control state
  logic [4:0]  dlen;                        // descriptor size
  logic [2:0]  s_adr, d_adr;                // target addresses
  logic [31:0] cnt_f, lba_a, lba_b;         // count and addresses
  logic [31:0] resid;                       // blocks left
  logic        rsv_bad;                     // reserved bits set
  logic        mode_bad;                    // unsupported copy mode
  logic        len_bad;                     // seq length unsupported
  logic        last_seg;                    // list exhausted
  always_comb begin
    dlen  = (q.fc == `CCS_FC_DA_DA) ? `CCS_DLEN_DA : `CCS_DLEN_SA;
    s_adr = q.desc[0][`CCS_ADDR_HI:`CCS_ADDR_LO];
    d_adr = q.desc[1][`CCS_ADDR_HI:`CCS_ADDR_LO];
    cnt_f = {q.desc[4], q.desc[5], q.desc[6], q.desc[7]};
    lba_a = {q.desc[8], q.desc[9], q.desc[10], q.desc[11]};
    lba_b = {q.desc[12], q.desc[13], q.desc[14], q.desc[15]};
    resid = cnt_f - q.cnt;
    rsv_bad = (q.desc[0][`CCS_RSV_HI:`CCS_RSV_LO] != 2'b00) ||
              (q.desc[1][`CCS_RSV_HI:`CCS_RSV_LO] != 2'b00);
    // third party: neither end is this device
    mode_bad = ((s_adr != own_addr_i) && (d_adr != own_addr_i) &&
                !third_party_en_i) ||
               ((s_adr != own_addr_i || d_adr != own_addr_i) &&
                !remote_en_i);
    len_bad  = (q.fc != `CCS_FC_DA_DA) &&
               ({q.desc[2], q.desc[3]} > max_blklen_i);
    last_seg = q.rem == 24'h000000;
  end

  // ----------------------------------------
  // segment outputs
  // ----------------------------------------
  always_comb begin
    seg_valid_o    = (q.st == ST_XFER) && !q.issued && (cnt_f != 32'h00000000);
    seg_num_o      = q.seg;
    seg_src_addr_o = s_adr;
    seg_dst_addr_o = d_adr;
    seg_src_lun_o  = q.desc[0][`CCS_LUN_HI:`CCS_LUN_LO];
    seg_dst_lun_o  = q.desc[1][`CCS_LUN_HI:`CCS_LUN_LO];
    seg_blklen_o   = (q.fc == `CCS_FC_DA_DA) ? 16'h0000 : {q.desc[2], q.desc[3]};
    seg_count_o    = cnt_f;
    // the direct-access side takes the single address of 00h/01h
    unique case (q.fc)
      `CCS_FC_DA_SA: begin
        seg_src_lba_o = lba_a;
        seg_dst_lba_o = 32'h00000000;
      end
      `CCS_FC_SA_DA: begin
        seg_src_lba_o = 32'h00000000;
        seg_dst_lba_o = lba_a;
      end
      default: begin
        seg_src_lba_o = lba_a;
        seg_dst_lba_o = lba_b;
      end
    endcase
  end

  // ----------------------------------------
  // controller
  // ----------------------------------------
  logic       we;                           // sense area write
  logic [7:0] wa, wd;                       // write address, data
  logic       own_f;                        // self-detected fault
  logic [3:0] own_k;                        // its sense key
  always_comb begin
    d        = q;
    d.done   = 1'b0;
    we       = 1'b0;
    wa       = q.wp;
    wd       = 8'h00;
    pop      = 1'b0;
    own_f    = 1'b0;
    own_k    = `CCS_KEY_ILLEGAL;
    req_sense_o     = 1'b0;
    tgt_sns_ready_o = 1'b0;
    unique case (q.st)
      ST_IDLE: begin
        if (start_i) begin
          d.fc   = func_i;
          d.rem  = list_len_i;
          d.seg  = 8'h00;
          d.bidx = 4'h0;
          d.desc = '0;
          d.cnt  = 32'h00000000;
          d.soff = 8'h00;
          d.doff = 8'h00;
          d.wp   = `CCS_SNS_AREA;
          d.key  = 4'h0;
          d.chk  = 1'b0;
          if (func_i > `CCS_FC_DA_DA) begin
            own_f = 1'b1;
          end else if (list_len_i == 24'h000000) begin
            d.st = ST_FIN;                                         // empty list
          end else begin
            d.st = ST_FETCH;
          end
        end
      end
      ST_FETCH: begin
        // a partial descriptor at the end of the list is invalid
        if (q.rem < {19'h00000, dlen}) begin
          own_f = 1'b1;
        end else begin
          pop = f_vld;
          if (f_vld) begin
            d.desc[q.bidx] = f_dat;
            d.bidx = q.bidx + 4'h1;
            if (q.bidx == 4'(dlen - 5'd1)) begin
              d.bidx = 4'h0;
              d.st   = ST_CHECK;
            end
          end
        end
      end
      ST_CHECK: begin
        d.rem    = q.rem - {19'h00000, dlen};
        d.cnt    = 32'h00000000;
        d.issued = 1'b0;
        if (rsv_bad || mode_bad || len_bad) begin
          own_f = 1'b1;
        end else begin
          d.st = ST_XFER;
        end
      end
      ST_XFER: begin
        if (tgt_chk_i) begin
          // status byte opens this target's area
          we = 1'b1;
          wd = tgt_status_i;
          if (tgt_is_dst_i) begin
            d.doff = q.wp;
          end else begin
            d.soff = q.wp;
          end
          d.wp = q.wp + 8'h01;
          req_sense_o = 1'b1;
          d.st = ST_TGT;
        end else if (self_fail_i) begin
          // own data-transfer failure: sense is made here
          if (tgt_is_dst_i) begin
            d.doff = q.wp;
          end else begin
            d.soff = q.wp;
          end
          d.ikey = self_key_i;
          d.bidx = 4'h0;
          d.st   = ST_SELF;
        end else if (seq_len_bad_i) begin
          own_f = 1'b1;
          own_k = `CCS_KEY_COPYABT;
        end else if (!q.issued && cnt_f != 32'h00000000) begin
          d.issued = seg_ready_i;
        end else if (cnt_f == 32'h00000000 ||
                     (blk_done_i && q.cnt + 32'h1 == cnt_f)) begin
          // segment finished, or empty and skipped
          d.cnt = cnt_f;
          if (last_seg) begin
            d.st = ST_FIN;
          end else if (q.seg == `CCS_SEG_LAST) begin
            own_f = 1'b1;
          end else begin
            d.seg  = q.seg + 8'h01;
            d.desc = '0;
            d.cnt  = 32'h00000000;
            d.st   = ST_FETCH;
          end
        end else if (blk_done_i) begin
          d.cnt = q.cnt + 32'h1;
        end
      end
      ST_TGT: begin
        tgt_sns_ready_o = 1'b1;
        if (tgt_sns_valid_i) begin
          we = 1'b1;
          wd = tgt_sns_data_i;
          // bytes past the buffer are dropped, pointer saturates, except at SNS_DEPTH 256 where it wraps to 0
          if ({1'b0, q.wp} < 9'(SNS_DEPTH)) begin
            d.wp = q.wp + 8'h01;
          end
          if (tgt_sns_last_i) begin
            d.key = `CCS_KEY_COPYABT;
            d.chk = 1'b1;
            d.st  = ST_FIN;
          end
        end
      end
      ST_SELF: begin
        // status, then a short extended sense with the failure key
        we = 1'b1;
        unique case (q.bidx[1:0])
          2'd0:    wd = `CCS_STAT_CHECK;
          2'd1:    wd = `CCS_SNS_EXT;
          2'd2:    wd = 8'h00;
          default: wd = {4'h0, q.ikey};
        endcase
        d.wp   = q.wp + 8'h01;
        d.bidx = q.bidx + 4'h1;
        if (q.bidx == 4'h3) begin
          d.bidx = 4'h0;
          d.key  = `CCS_KEY_COPYABT;
          d.chk  = 1'b1;
          d.st   = ST_FIN;
        end
      end
      ST_FIN: begin
        d.done = 1'b1;
        d.st   = ST_IDLE;
      end
    endcase
    // bus parity and management faults preempt any busy state except ST_FIN
    if (q.st != ST_IDLE && q.st != ST_FIN && parity_err_i) begin
      own_f = 1'b1;
      own_k = `CCS_KEY_ABT_CMD;
    end else if (q.st != ST_IDLE && q.st != ST_FIN && mgmt_fail_i) begin
      own_f = 1'b1;
      own_k = mgmt_key_i;
    end
    if (own_f) begin
      we     = 1'b0;
      req_sense_o = 1'b0;                                          // no fetch once aborting
      d.key  = own_k;
      d.chk  = 1'b1;
      d.soff = 8'h00;
      d.doff = 8'h00;
      d.wp   = `CCS_SNS_AREA;
      d.st   = ST_FIN;
    end
    if ({1'b0, wa} >= 9'(SNS_DEPTH)) begin
      we = 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else if (ce_i) begin
      q <= d;
    end
  end

  // ----------------------------------------
  // sense storage and readout
  // ----------------------------------------
  localparam int SAW = $clog2(SNS_DEPTH);
  logic [7:0] sns_mem [SNS_DEPTH];          // recovered status and sense
  logic [7:0] rd_d, rd_q;                   // readout byte
  // header bytes are built from live state, areas come from memory
  always_comb begin
    unique case (sns_addr_i)
      8'h00:   rd_d = q.chk ? `CCS_SNS_HDR : 8'h00;
      8'h01:   rd_d = q.seg;
      8'h02:   rd_d = {4'h0, q.key};
      8'h03:   rd_d = resid[31:24];
      8'h04:   rd_d = resid[23:16];
      8'h05:   rd_d = resid[15:8];
      8'h06:   rd_d = resid[7:0];
      8'h07:   rd_d = q.wp - `CCS_SNS_ALEN;
      8'h08:   rd_d = q.soff;
      8'h09:   rd_d = q.doff;
      default: rd_d = ({1'b0, sns_addr_i} < 9'(SNS_DEPTH)) ?
                      sns_mem[sns_addr_i[SAW-1:0]] : 8'h00;
    endcase
  end
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      rd_q <= 8'h00;
    end else if (ce_i) begin
      rd_q <= rd_d;
    end
  end
  // memory holds no reset; the pointer bounds what is valid
  always_ff @(posedge clk_i) begin
    if (ce_i && we) begin
      sns_mem[wa[SAW-1:0]] <= wd;
    end
  end

  // ----------------------------------------
  // status outputs
  // ----------------------------------------
  assign busy_o     = q.st != ST_IDLE;
  assign done_o     = q.done;
  assign chk_cond_o = q.chk;
  assign sns_len_o  = q.wp;
  assign sns_data_o = rd_q;
endmodule : ccs_copy_mgr
`default_nettype wire

/* ccs_map.svh */
`ifndef CCS_MAP_SVH
`define CCS_MAP_SVH
// descriptor sizes per function code
`define CCS_DLEN_SA     5'd12
`define CCS_DLEN_DA     5'd16
`define CCS_FC_DA_SA    8'h00
`define CCS_FC_SA_DA    8'h01
`define CCS_FC_DA_DA    8'h02
// descriptor byte 0/1 field positions
`define CCS_ADDR_HI     7
`define CCS_ADDR_LO     5
`define CCS_RSV_HI      4
`define CCS_RSV_LO      3
`define CCS_LUN_HI      2
`define CCS_LUN_LO      0
// last legal segment index
`define CCS_SEG_LAST    8'hFF
// sense keys
`define CCS_KEY_ILLEGAL 4'h5
`define CCS_KEY_ABT_CMD 4'hB
`define CCS_KEY_COPYABT 4'hA
// sense layout
`define CCS_SNS_HDR     8'hF0
`define CCS_SNS_ALEN    8'h08
`define CCS_SNS_AREA    8'h0A
`define CCS_STAT_CHECK  8'h02
`define CCS_SNS_EXT     8'h70
`endif

/* ccs_pkg.sv */
`default_nettype none
package ccs_pkg;
  // controller states, gray along idle-fetch-check-xfer
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_FETCH = 3'b001,
    ST_CHECK = 3'b011,
    ST_XFER  = 3'b010,
    ST_TGT   = 3'b110,
    ST_SELF  = 3'b111,
    ST_FIN   = 3'b100
  } ccs_state_e;
  // controller state record
  typedef struct packed {
    ccs_state_e       st;
    logic [7:0]       fc;
    logic [3:0]       bidx;
    logic [15:0][7:0] desc;
    logic [23:0]      rem;
    logic [7:0]       seg;
    logic             issued;
    logic [31:0]      cnt;
    logic [3:0]       key;
    logic [3:0]       ikey;
    logic [7:0]       soff;
    logic [7:0]       doff;
    logic [7:0]       wp;
    logic             done;
    logic             chk;
  } ccs_ctl_s;
endpackage : ccs_pkg
`default_nettype wire

/* ccs_fifo.sv */
`default_nettype none
module ccs_fifo #(
  parameter int W = 8,
  parameter int D = 8
) (
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  input  wire logic         ce_i,
  input  wire logic         in_valid_i,
  input  wire logic [W-1:0] in_data_i,
  output logic              in_ready_o,
  output logic              out_valid_o,
  output logic [W-1:0]      out_data_o,
  input  wire logic         out_ready_i
);
  localparam int AW = $clog2(D);
  if (D < 2 || (1 << AW) != D) begin : g_bad
    $error("fifo depth must be a power of two");
  end
  logic [W-1:0] mem [D];
  logic [AW:0]  wp_q, wp_d, rp_q, rp_d;
  logic         push, pop;
  // full when pointers differ only in the wrap bit
  always_comb begin
    in_ready_o  = (wp_q ^ rp_q) != {1'b1, {AW{1'b0}}};
    out_valid_o = wp_q != rp_q;
    out_data_o  = mem[rp_q[AW-1:0]];
    push        = in_valid_i && in_ready_o;
    pop         = out_valid_o && out_ready_i;
    wp_d        = wp_q + (AW+1)'(push);
    rp_d        = rp_q + (AW+1)'(pop);
  end
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wp_q <= '0;
      rp_q <= '0;
    end else if (ce_i) begin
      wp_q <= wp_d;
      rp_q <= rp_d;
    end
  end
  // storage carries no reset
  always_ff @(posedge clk_i) begin
    if (ce_i && push) begin
      mem[wp_q[AW-1:0]] <= in_data_i;
    end
  end
endmodule : ccs_fifo
`default_nettype wire

/* ccs_tgt_model.sv */
`default_nettype none
// ------------------------------------------------
// managed target and data mover model
// ------------------------------------------------
module ccs_tgt_model #(
  parameter int FAIL_AT = 1  // blocks moved before a fault
) (
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        slow_i,     // blocks every other cycle
  input  wire logic        fail_en_i,  // report check condition
  input  wire logic        seg_valid_i,
  input  wire logic [31:0] seg_count_i,
  output logic             seg_ready_o,
  output logic             blk_done_o,
  output logic             tgt_chk_o,
  input  wire logic        req_sense_i,
  input  wire logic        sns_ready_i,
  output logic             sns_valid_o,
  output logic [7:0]       sns_data_o,
  output logic             sns_last_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] left_q;  // blocks still to move
  logic [31:0] n_q;     // blocks moved in segment
  logic        ph_q;    // slow phase
  logic [2:0]  k_q;     // sense byte index
  // one-shot ready, then the block pulses
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      {seg_ready_o, blk_done_o, tgt_chk_o, ph_q} <= '0;
      left_q <= '0;
      n_q    <= '0;
    end else begin
      ph_q        <= ~ph_q;
      seg_ready_o <= seg_valid_i && !seg_ready_o && left_q == 0;
      blk_done_o  <= 1'b0;
      tgt_chk_o   <= 1'b0;
      if (seg_ready_o) begin
        left_q <= seg_count_i;
        n_q    <= '0;
      end else if (left_q != 0 && !(slow_i && ph_q)) begin
        if (fail_en_i && n_q == FAIL_AT) begin
          tgt_chk_o <= 1'b1;
          left_q    <= '0;
        end else begin
          blk_done_o <= 1'b1;
          left_q     <= left_q - 1;
          n_q        <= n_q + 1;
        end
      end
    end
  end
  // four sense bytes; a released data line is scrambled, not held
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      {sns_valid_o, sns_last_o, k_q, sns_data_o} <= '0;
    end else if (req_sense_i) begin
      sns_valid_o <= 1'b1;
      k_q         <= '0;
      sns_data_o  <= 8'hC0;
      sns_last_o  <= 1'b0;
    end else if (sns_valid_o && sns_ready_i) begin
      sns_valid_o <= !sns_last_o;
      k_q         <= k_q + 3'h1;
      sns_data_o  <= sns_last_o ? ~sns_data_o : sns_data_o + 8'h01;
      sns_last_o  <= k_q == 3'h2;
    end
  end
endmodule : ccs_tgt_model
`default_nettype wire

/* ccs_copy_mgr_chk.sv */
`default_nettype none
// ------------------------------------------------
// copy manager port checker
// ------------------------------------------------
module ccs_copy_mgr_chk (
  input wire logic        clk_i,
  input wire logic        rst_n_i,
  input wire logic        ce_i,
  input wire logic        start_i,
  input wire logic [7:0]  func_i,
  input wire logic        busy_o,
  input wire logic        done_o,
  input wire logic        chk_cond_o,
  input wire logic        parity_err_i,
  input wire logic        mgmt_fail_i,
  input wire logic        tgt_chk_i,
  input wire logic        req_sense_o,
  input wire logic        tgt_sns_ready_o,
  input wire logic        tgt_sns_valid_i,
  input wire logic        tgt_sns_last_i,
  input wire logic        seg_valid_o,
  input wire logic        seg_ready_i,
  input wire logic [31:0] seg_count_o,
  input wire logic [31:0] seg_src_lba_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  // copy ends flagged
  sequence s_end;
    done_o && chk_cond_o;
  endsequence
  // sense fetch handshake
  sequence s_fetch;
    req_sense_o ##1 tgt_sns_ready_o;
  endsequence
  property p_bad_func;
    start_i && ce_i && !busy_o && func_i > 8'h02 |-> ##[1:4] s_end;
  endproperty
  a_bad_func: assert property (p_bad_func) else $error("bad code not ended");
  property p_fault;
    (parity_err_i || mgmt_fail_i) && busy_o |-> ##[1:4] s_end;
  endproperty
  a_fault: assert property (p_fault) else $error("fault not ended");
  property p_sense_cause;
    req_sense_o |-> tgt_chk_i && busy_o;
  endproperty
  a_sense_cause: assert property (p_sense_cause) else $error("stray fetch");
  property p_sense_seq;
    tgt_chk_i && busy_o && !parity_err_i && !mgmt_fail_i |-> s_fetch;
  endproperty
  a_sense_seq: assert property (p_sense_seq) else $error("no sense fetch");
  property p_tgt_end;
    tgt_sns_valid_i && tgt_sns_ready_o && tgt_sns_last_i |-> ##[1:3] s_end;
  endproperty
  a_tgt_end: assert property (p_tgt_end) else $error("target fault not ended");
  property p_chk_stand;
    chk_cond_o && !start_i |=> chk_cond_o;
  endproperty
  a_chk_stand: assert property (p_chk_stand) else $error("status dropped");
  property p_seg_hold;
    seg_valid_o && !seg_ready_i |=> seg_valid_o && $stable(seg_count_o)
      && $stable(seg_src_lba_o);
  endproperty
  a_seg_hold: assert property (p_seg_hold) else $error("segment moved");
  property p_zero_cnt;
    seg_valid_o |-> seg_count_o != 32'h0;
  endproperty
  a_zero_cnt: assert property (p_zero_cnt) else $error("empty segment sent");
  property p_done;
    done_o |-> !busy_o ##1 !done_o;
  endproperty
  a_done: assert property (p_done) else $error("done not a pulse");
endmodule : ccs_copy_mgr_chk
`default_nettype wire

/* testbench.sv */
`default_nettype none
// ------------------------------------------------
// copy manager bench
// ------------------------------------------------
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_i, rst_n_i, ce_i, start_i, third_party_en_i, remote_en_i;
  logic        parity_err_i, mgmt_fail_i, par_valid_i, seq_len_bad_i, self_fail_i;
  logic        tgt_is_dst_i, par_ready_o, seg_valid_o, seg_ready_i, blk_done_i, tgt_chk_i;
  logic        req_sense_o, tgt_sns_valid_i, tgt_sns_last_i, tgt_sns_ready_o;
  logic        busy_o, done_o, chk_cond_o, slow, fail_en;
  logic [2:0]  own_addr_i, seg_src_addr_o, seg_src_lun_o, seg_dst_addr_o, seg_dst_lun_o;
  logic [3:0]  mgmt_key_i, self_key_i;
  logic [7:0]  func_i, par_data_i, seg_num_o, tgt_status_i, tgt_sns_data_i;
  logic [7:0]  sns_len_o, sns_addr_i, sns_data_o;
  logic [15:0] max_blklen_i, seg_blklen_o, c_bl;
  logic [23:0] list_len_i;
  logic [31:0] seg_count_o, seg_src_lba_o, seg_dst_lba_o, c_cnt, c_sl, c_dl;
  logic [11:0] c_ad;           // captured units and addresses
  logic [7:0]  pl[$];          // parameter list bytes
  int          n_fail, total_checks, inj, nh, cyc;
  ccs_copy_mgr dut (.*);
  ccs_tgt_model far (.clk_i, .rst_n_i, .slow_i(slow), .fail_en_i(fail_en),
    .seg_valid_i(seg_valid_o), .seg_count_i(seg_count_o), .seg_ready_o(seg_ready_i),
    .blk_done_o(blk_done_i), .tgt_chk_o(tgt_chk_i), .req_sense_i(req_sense_o),
    .sns_ready_i(tgt_sns_ready_o), .sns_valid_o(tgt_sns_valid_i),
    .sns_data_o(tgt_sns_data_i), .sns_last_o(tgt_sns_last_i));
  always #10 clk_i = ~clk_i;
  // hang guard, far above the longest run
  always @(posedge clk_i) if (++cyc > 20000) begin
    n_fail++;
    end_sim();
  end
  task automatic end_sim();
    if (n_fail == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : end_sim
  task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask : cmp
  task automatic dsc(input logic [127:0] v, input int n);
    for (int k = 0; k < n; k++) pl.push_back(v[127-8*k -: 8]);
  endtask : dsc
  // one copy: stream the list, inject a fault after a block of segment 1
  task automatic run(input logic [7:0] fc);
    int   i;
    logic tk, fire;
    i = 0;
    fire = 1'b0;
    nh = 0;
    func_i <= fc;
    list_len_i <= 24'(pl.size());
    start_i <= 1'b1;
    @(posedge clk_i);
    start_i <= 1'b0;
    forever begin
      par_valid_i <= i < pl.size();
      par_data_i <= i < pl.size() ? pl[i] : 8'(~i);
      seq_len_bad_i <= fire && inj == 1;
      self_fail_i <= fire && inj == 2;
      parity_err_i <= fire && inj == 3;
      mgmt_fail_i <= fire && inj == 4;
      if (fire) inj = 0;
      @(negedge clk_i);
      tk = par_valid_i && par_ready_o;
      fire = blk_done_i === 1'b1 && seg_num_o === 8'h01 && inj != 0;
      if (seg_valid_o && seg_ready_i) begin
        nh++;
        {c_cnt, c_sl, c_dl, c_bl} = {seg_count_o, seg_src_lba_o, seg_dst_lba_o, seg_blklen_o};
        c_ad = {seg_src_addr_o, seg_src_lun_o, seg_dst_addr_o, seg_dst_lun_o};
      end
      if (done_o === 1'b1) break;
      @(posedge clk_i);
      if (tk) i++;
    end
    @(posedge clk_i);
    {par_valid_i, seq_len_bad_i, self_fail_i, parity_err_i, mgmt_fail_i} <= '0;
  endtask : run
  task automatic sns(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_i);
    sns_addr_i <= a;
    @(posedge clk_i);
    @(negedge clk_i);
    cmp($sformatf("sense_%0d", a), {24'h0, e}, {24'h0, sns_data_o});
  endtask : sns
  // good segment 0, then a segment 1 of three blocks that fails
  task automatic err(input logic [7:0] fc, b0, b1, input logic [15:0] bl, input int ij,
                     input logic fe, dst, input logic [3:0] k, input logic [31:0] r,
                     input logic [7:0] len);
    logic [7:0] ofs;
    pl = {};
    if (fc != 8'h03) begin
      dsc({8'h22, 8'h25, 16'h0200, 32'h1, 64'h0}, 12);
      dsc({b0, b1, bl, 32'h3, 64'h0}, 12);
    end
    inj = ij;
    fail_en <= fe;
    tgt_is_dst_i <= dst;
    tgt_status_i <= dst ? 8'h18 : 8'h02;
    run(fc);
    ofs = len > 8'd10 ? 8'h0A : 8'h00;
    cmp("chk_cond", 1, chk_cond_o);
    cmp("sns_len", len, sns_len_o);
    sns(8'd0, 8'hF0);
    sns(8'd1, fc == 8'h03 ? 8'h00 : 8'h01);
    sns(8'd2, {4'h0, k});
    for (int j = 0; j < 4; j++) sns(8'(3 + j), r[31-8*j -: 8]);
    sns(8'd7, len - 8'd8);
    sns(8'd8, dst ? 8'h00 : ofs);
    sns(8'd9, dst ? ofs : 8'h00);
    if (fe) for (int j = 0; j < 5; j++) sns(8'(10 + j), j ? 8'(8'hBF + j) : tgt_status_i);
    if (ij == 2) for (int j = 0; j < 4; j++) sns(8'(10 + j), 8'(32'h0270_0003 >> (24 - 8 * j)));
  endtask : err
  initial begin
    {clk_i, rst_n_i, start_i, par_valid_i, seq_len_bad_i, self_fail_i} = '0;
    {parity_err_i, mgmt_fail_i, tgt_is_dst_i, slow, fail_en} = '0;
    {ce_i, third_party_en_i, remote_en_i} = '1;
    {own_addr_i, mgmt_key_i, self_key_i, max_blklen_i} = {3'h1, 4'h4, 4'h3, 16'h0200};
    {func_i, par_data_i, tgt_status_i, sns_addr_i, list_len_i} = '0;
    {n_fail, total_checks, inj, cyc} = '0;
    repeat (6) @(posedge clk_i);
    rst_n_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    // third-party copy allowed, second segment of zero blocks
    for (int f = 0; f < 2; f++) begin
      pl = {};
      dsc({8'h42, 8'h65, 16'h0200, 32'h2, 32'h11223344, 32'h0}, 12);
      dsc({8'h42, 8'h65, 16'h0200, 96'h0}, 12);
      run(8'(f));
      cmp("handshakes", 1, nh);
      cmp("chk_cond", 0, chk_cond_o);
      cmp("count", 2, c_cnt);
      cmp("blklen", 16'h0200, c_bl);
      cmp("units", 12'h49D, c_ad);
      cmp("lba", 32'h11223344, f ? c_dl : c_sl);
    end
    pl = {};
    dsc({8'h42, 8'h65, 16'h0, 32'h1, 32'hAABBCCDD, 32'h01020304}, 16);
    run(8'h02);
    cmp("src_lba", 32'hAABBCCDD, c_sl);
    cmp("dst_lba", 32'h01020304, c_dl);
    cmp("blklen", 0, c_bl);
    {third_party_en_i, remote_en_i, slow} <= 3'b001;
    err(8'h03, 8'h22, 8'h25, 16'h0200, 0, 0, 0, 4'h5, 0, 10);
    err(8'h00, 8'h42, 8'h65, 16'h0200, 0, 0, 0, 4'h5, 3, 10);
    err(8'h00, 8'h22, 8'h65, 16'h0200, 0, 0, 0, 4'h5, 3, 10);
    err(8'h01, 8'h22, 8'h25, 16'h0201, 0, 0, 0, 4'h5, 3, 10);
    err(8'h00, 8'h3A, 8'h25, 16'h0200, 0, 0, 0, 4'h5, 3, 10);
    err(8'h00, 8'h22, 8'h25, 16'h0200, 1, 0, 0, 4'hA, 2, 10);
    err(8'h00, 8'h22, 8'h25, 16'h0200, 3, 0, 0, 4'hB, 2, 10);
    err(8'h00, 8'h22, 8'h25, 16'h0200, 4, 0, 0, 4'h4, 2, 10);
    err(8'h00, 8'h22, 8'h25, 16'h0200, 2, 0, 0, 4'hA, 2, 14);
    err(8'h00, 8'h22, 8'h25, 16'h0200, 0, 1, 0, 4'hA, 2, 15);
    err(8'h01, 8'h22, 8'h25, 16'h0200, 0, 1, 1, 4'hA, 2, 15);
    end_sim();
  end
endmodule : testbench
bind ccs_copy_mgr ccs_copy_mgr_chk chk (.*);
`default_nettype wire
